/* inc/anp_pkg.sv */
// constants, register map and state type for the link auto-negotiation block
package anp_pkg;
  // core clock rate
  localparam int CLK_MHZ = 250;
  // spacing between adjacent pulse positions of a fast link pulse burst
  localparam int PULSE_GAP_NS  = 62500;
  localparam int PULSE_GAP_CYC = (PULSE_GAP_NS * CLK_MHZ) / 1000;
  // burst repetition interval
  localparam int BURST_GAP_US  = 16000;
  localparam int BURST_GAP_CYC = BURST_GAP_US * CLK_MHZ;
  // longest wait for a received burst before giving up
  localparam int NO_BURST_US   = 50000;
  localparam int NO_BURST_CYC  = NO_BURST_US * CLK_MHZ;
  // link drop time after a software restart
  localparam int BREAK_LINK_MS  = 1200;
  localparam int BREAK_LINK_CYC = BREAK_LINK_MS * 1000 * CLK_MHZ;

  // register indices, byte address is index times four
  localparam logic [5:0] REG_CTRL    = 6'h00;
  localparam logic [5:0] REG_STATUS  = 6'h01;
  localparam logic [5:0] REG_ADV     = 6'h04;
  localparam logic [5:0] REG_PARTNER = 6'h05;
  localparam logic [5:0] REG_EXPAND  = 6'h06;
  localparam logic [5:0] REG_VENDOR  = 6'h1F;

  // field positions
  localparam int CTRL_SOFT_RST = 15;
  localparam int CTRL_SPEED    = 13;
  localparam int CTRL_AN_EN    = 12;
  localparam int CTRL_PDOWN    = 11;
  localparam int CTRL_RESTART  = 9;
  localparam int CTRL_DUPLEX   = 8;
  localparam int STAT_AN_DONE  = 5;
  localparam int STAT_AN_ABLE  = 3;
  localparam int STAT_LINK     = 2;
  localparam int ABIL_LO       = 5;
  localparam int LCW_ACK       = 14;
  localparam int EXP_PD_FAULT  = 4;
  localparam int EXP_LP_ABLE   = 0;
  localparam int VEND_DONE     = 12;
  localparam int VEND_SPD_LO   = 2;

  // link code word constants
  localparam logic [4:0]  SELECTOR  = 5'h01;
  localparam logic [15:0] LCW_MASK  = 16'hBFFF;
  localparam logic [2:0]  MATCH_NEED = 3'h3;
  localparam logic [2:0]  ACK_NEED   = 3'h3;
  localparam logic [3:0]  ACK_TAIL   = 4'h6;
  localparam logic [5:0]  LAST_POS   = 6'h20;

  typedef enum logic [2:0] {
    st_hold, st_forced, st_break, st_detect, st_ack_wait, st_ack_tail, st_linked
  } an_state_t;
endpackage

/* rtl/link_autonegotiation.sv */
// auto-negotiation engine with avalon-mm register slave
//
// Notes on behaviour
// RL1: with negotiation enabled, start on any reset, link loss or restart bit
// RL2: every start opens with fast link pulse bursts on the 10M pulse output; a restart-bit start sends none until the break time ends
// RL3: a burst holds at most 33 positions; 17 clock pulses always sent
// RL4: 16 odd positions carry the code word; pulse means one
// RL5: first five code word bits carry the 802.3 selector value
// RL6: technology ability bits mirror the advertisement register
// RL7: resolve 100 full, then 100 half, then 10 full, then 10 half
// RL8: after an ability match keep sending the word with acknowledge set
// RL9: changed partner content during acknowledge restarts negotiation
// RL10: missing received bursts restart negotiation
// RL11: straps latched after reset give enable and initial abilities
// RL12: advertisement writes to bits 8..5 change abilities without restarting
// RL13: software must set restart after changing abilities
// RL14: clearing the enable bit disables negotiation
// RL15: no next page; only the base code word is handled
// RL16: with no fast pulses, speed comes from 100M symbols or 10M pulses; code skips this once the no-burst watchdog has run out in detect
// RL17: a parallel detected link is always half duplex
// RL18: parallel detected link clears the partner-can-negotiate flag
// RL19: a parallel detection fault sets the fault status bit
// RL20: partner register holds received abilities, or detected speed
// RL21: link loss restarts negotiation
// RL22: restart bit drops the link for the break time, then negotiates
// RL23: completion reports speed and duplex and partner abilities
// RL24: disabled negotiation forces speed and duplex from control bits
// RL25: pulse, burst and timer values follow the standard's figures
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module link_autonegotiation #(
  parameter int unsigned PULSE_GAP_CYC  = anp_pkg::PULSE_GAP_CYC,
  parameter int unsigned BURST_GAP_CYC  = anp_pkg::BURST_GAP_CYC,
  parameter int unsigned NO_BURST_CYC   = anp_pkg::NO_BURST_CYC,
  parameter int unsigned BREAK_LINK_CYC = anp_pkg::BREAK_LINK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [2:0]  mode_strap,
  input  wire logic        rx_pulse,
  input  wire logic        link_100_ok,
  input  wire logic        link_10_ok,
  output logic             tx_pulse,
  output logic             link_hold,
  output logic             link_up,
  output logic             speed_100,
  output logic             full_duplex
);
  // gap classes on the receive side derive from the nominal spacing
  localparam int unsigned HALF_GAP = (PULSE_GAP_CYC * 3) / 2;
  localparam int unsigned END_GAP  = PULSE_GAP_CYC * 4;

  typedef struct packed {
    anp_pkg::an_state_t st;
    logic        strap_done;
    logic        an_en;
    logic        speed_sel;
    logic        duplex_sel;
    logic        pdown;
    logic [3:0]  adv;
    logic [15:0] partner;
    logic        lp_an_able;
    logic        pd_fault;
    logic        an_done;
    logic        res_speed;
    logic        res_full;
    logic        link_up;
    logic [31:0] timer;
    logic [31:0] btimer;
    logic [31:0] ptimer;
    logic [31:0] nob;
    logic        tx_active;
    logic [5:0]  tx_pos;
    logic        tx_pulse;
    logic [3:0]  sent_cnt;
    logic [31:0] rgap;
    logic        rin_burst;
    logic        got_one;
    logic [3:0]  rbit;
    logic [15:0] rword;
    logic        rx_new;
    logic [15:0] rx_word;
    logic [2:0]  match_cnt;
    logic [2:0]  ack_cnt;
    logic        bus_ack;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t next_q;

  // strap decode: high bit enables negotiation, low bits pick abilities
  function automatic logic strap_an(input logic [2:0] m);
    return m[2];
  endfunction

  function automatic logic [3:0] strap_adv(input logic [2:0] m);
    if (m[2]) begin
      return (m[1:0] == 2'h3) ? 4'hF : 4'h4;
    end
    return 4'h1 << m[1:0];
  endfunction

  // highest common ability, {speed_100, full}
  function automatic logic [1:0] resolve(input logic [3:0] c);
    if (c[3]) begin
      return 2'h3;
    end else if (c[2]) begin
      return 2'h2;
    end else if (c[1]) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  logic [15:0] tx_word;
  logic        ack_phase;
  logic        sending;
  logic        data_bit;
  logic [5:0]  idx;
  logic [1:0]  res;

  assign ack_phase = (q.st == anp_pkg::st_ack_wait) || (q.st == anp_pkg::st_ack_tail);
  assign sending   = ack_phase || (q.st == anp_pkg::st_detect);
  // base page only, next page and remote fault stay zero
  assign tx_word   = {1'b0, ack_phase, 1'b0, 4'h0, q.adv, anp_pkg::SELECTOR}; // RL5 RL6 RL8 RL15
  assign data_bit  = tx_word[q.tx_pos[4:1]];
  assign idx       = address[7:2];
  assign res       = resolve(q.adv & q.partner[8:5]);

  // outputs
  assign waitrequest = (read || write) && !q.bus_ack;
  assign readdata    = q.rdata;
  assign tx_pulse    = q.tx_pulse;
  assign link_hold   = (q.st == anp_pkg::st_break);
  assign link_up     = q.link_up;
  assign speed_100   = q.res_speed;
  assign full_duplex = q.res_full;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic start;
    logic brk;
    logic renego;
    logic ok;
    start  = 1'b0;
    brk    = 1'b0;
    renego = 1'b0;
    ok     = 1'b0;
    next_q = q;
    next_q.tx_pulse = 1'b0;
    next_q.bus_ack  = 1'b0;
    next_q.rx_new   = 1'b0;

    // straps are caught one edge after reset release
    if (!q.strap_done) begin
      next_q.strap_done = 1'b1;
      next_q.an_en      = strap_an(mode_strap); // RL11
      next_q.adv        = strap_adv(mode_strap); // RL11
      next_q.speed_sel  = mode_strap[1];
      next_q.duplex_sel = mode_strap[0];
      start = 1'b1; // RL1
    end

    // bus slave, one wait cycle on every access
    if ((read || write) && !q.bus_ack) begin
      next_q.bus_ack = 1'b1;
      next_q.rdata   = 32'h0000_0000;
      if (write) begin
        case (idx)
          anp_pkg::REG_CTRL: begin
            next_q.speed_sel  = writedata[anp_pkg::CTRL_SPEED];
            next_q.duplex_sel = writedata[anp_pkg::CTRL_DUPLEX];
            next_q.an_en      = writedata[anp_pkg::CTRL_AN_EN]; // RL14
            next_q.pdown      = writedata[anp_pkg::CTRL_PDOWN];
            if (writedata[anp_pkg::CTRL_SOFT_RST]) begin
              next_q.strap_done = 1'b0; // reload strap values next edge
              next_q.pdown      = 1'b0;
            end
            if (writedata[anp_pkg::CTRL_AN_EN] != q.an_en ||
                writedata[anp_pkg::CTRL_PDOWN] != q.pdown) begin
              start = 1'b1; // RL1
            end
            if (writedata[anp_pkg::CTRL_RESTART]) begin
              start = 1'b1; // RL1
              brk   = 1'b1; // RL22
            end
          end
          // no restart here: the next burst sent carries the new abilities
          anp_pkg::REG_ADV: next_q.adv = writedata[8:5]; // RL12
          default: begin
          end
        endcase
      end else begin
        case (idx)
          anp_pkg::REG_CTRL: begin
            next_q.rdata[anp_pkg::CTRL_SPEED]  = q.speed_sel;
            next_q.rdata[anp_pkg::CTRL_AN_EN]  = q.an_en;
            next_q.rdata[anp_pkg::CTRL_PDOWN]  = q.pdown;
            next_q.rdata[anp_pkg::CTRL_DUPLEX] = q.duplex_sel;
          end
          anp_pkg::REG_STATUS: begin
            next_q.rdata[anp_pkg::STAT_AN_DONE] = q.an_done;
            next_q.rdata[anp_pkg::STAT_AN_ABLE] = 1'b1;
            next_q.rdata[anp_pkg::STAT_LINK]    = q.link_up;
          end
          anp_pkg::REG_ADV:     next_q.rdata[15:0] = {7'h00, q.adv, anp_pkg::SELECTOR};
          anp_pkg::REG_PARTNER: next_q.rdata[15:0] = q.partner; // RL20 RL23
          anp_pkg::REG_EXPAND: begin
            next_q.rdata[anp_pkg::EXP_PD_FAULT] = q.pd_fault;
            next_q.rdata[anp_pkg::EXP_LP_ABLE]  = q.lp_an_able;
            next_q.pd_fault = 1'b0; // clear on read, a new fault below wins
          end
          anp_pkg::REG_VENDOR: begin
            next_q.rdata[anp_pkg::VEND_DONE] = q.an_done;
            next_q.rdata[anp_pkg::VEND_SPD_LO +: 3] =
              {q.res_full, q.res_speed, !q.res_speed}; // RL23
          end
          default: begin
          end
        endcase
      end
    end

    // receive decoder: a long gap starts a burst, short gaps are data ones
    if (q.rgap != 32'hFFFF_FFFF) begin
      next_q.rgap = q.rgap + 32'h0000_0001;
    end
    if (rx_pulse) begin
      next_q.rgap = 32'h0000_0000;
      if (!q.rin_burst || q.rgap >= END_GAP) begin
        next_q.rin_burst = 1'b1;
        next_q.rbit      = 4'h0;
        next_q.got_one   = 1'b0;
      end else if (!q.got_one && q.rgap < HALF_GAP) begin
        next_q.got_one = 1'b1; // RL4
      end else begin
        next_q.rword   = {q.got_one, q.rword[15:1]};
        next_q.got_one = 1'b0;
        next_q.rbit    = q.rbit + 4'h1;
        if (q.rbit == 4'hF) begin
          next_q.rin_burst = 1'b0;
          next_q.rx_new    = 1'b1;
          next_q.rx_word   = {q.got_one, q.rword[15:1]};
        end
      end
    end else if (q.rin_burst && q.rgap >= END_GAP) begin
      next_q.rin_burst = 1'b0; // truncated burst is dropped
    end

    // transmit bursts: clock at even index, data at odd index
    if (!sending) begin
      next_q.tx_active = 1'b0;
      next_q.btimer    = 32'h0000_0000;
    end else begin
      if (q.btimer == 32'h0000_0000) begin
        next_q.btimer    = BURST_GAP_CYC - 32'h0000_0001; // RL25
        next_q.tx_active = 1'b1; // RL2
        next_q.tx_pos    = 6'h00;
        next_q.ptimer    = 32'h0000_0000;
      end else begin
        next_q.btimer = q.btimer - 32'h0000_0001;
      end
      if (q.tx_active) begin
        if (q.ptimer == 32'h0000_0000) begin
          next_q.tx_pulse = q.tx_pos[0] ? data_bit : 1'b1; // RL3 RL4
          next_q.ptimer   = PULSE_GAP_CYC - 32'h0000_0001; // RL25
          if (q.tx_pos == anp_pkg::LAST_POS) begin
            next_q.tx_active = 1'b0; // RL3
            next_q.sent_cnt  = q.sent_cnt + 4'h1;
          end else begin
            next_q.tx_pos = q.tx_pos + 6'h01;
          end
        end else begin
          next_q.ptimer = q.ptimer - 32'h0000_0001;
        end
      end
    end

    // watchdog on received words while negotiating
    if (q.rx_new || !sending) begin
      next_q.nob = 32'h0000_0000;
    end else begin
      next_q.nob = q.nob + 32'h0000_0001;
    end

    // arbitration
    case (q.st)
      anp_pkg::st_hold: begin
        next_q.link_up = 1'b0;
      end
      anp_pkg::st_forced: begin
        next_q.res_speed = q.speed_sel; // RL24
        next_q.res_full  = q.duplex_sel; // RL24
        next_q.link_up   = q.speed_sel ? link_100_ok : link_10_ok;
      end
      anp_pkg::st_break: begin
        if (q.timer >= BREAK_LINK_CYC - 32'h0000_0001) begin
          renego = 1'b1; // RL22
        end else begin
          next_q.timer = q.timer + 32'h0000_0001;
        end
      end
      anp_pkg::st_detect: begin
        if (q.rx_new) begin
          next_q.partner = q.rx_word; // RL20
          if ((q.rx_word & anp_pkg::LCW_MASK) == (q.partner & anp_pkg::LCW_MASK)) begin
            next_q.match_cnt = q.match_cnt + 3'h1;
            if (q.match_cnt + 3'h1 >= anp_pkg::MATCH_NEED) begin
              next_q.st         = anp_pkg::st_ack_wait; // RL8
              next_q.lp_an_able = 1'b1;
              next_q.ack_cnt    = 3'h0;
            end
          end else begin
            next_q.match_cnt = 3'h1;
          end
        end else if (q.nob >= NO_BURST_CYC) begin
          next_q.match_cnt = 3'h0;
        end else if (q.match_cnt == 3'h0 && !q.rin_burst) begin
          if (link_100_ok && link_10_ok) begin
            next_q.pd_fault = 1'b1; // RL19
          end else if (link_100_ok || link_10_ok) begin
            next_q.st         = anp_pkg::st_linked; // RL16
            next_q.res_speed  = link_100_ok; // RL16
            next_q.res_full   = 1'b0; // RL17
            next_q.lp_an_able = 1'b0; // RL18
            next_q.partner    = {8'h00, link_100_ok, 1'b0, link_10_ok, 5'h00}; // RL20
            next_q.an_done    = 1'b1;
            next_q.link_up    = 1'b1;
          end
        end
      end
      anp_pkg::st_ack_wait, anp_pkg::st_ack_tail: begin
        if (q.rx_new &&
            (q.rx_word & anp_pkg::LCW_MASK) != (q.partner & anp_pkg::LCW_MASK)) begin
          renego = 1'b1; // RL9
        end else if (q.nob >= NO_BURST_CYC) begin
          renego = 1'b1; // RL10
        end else if (q.st == anp_pkg::st_ack_wait) begin
          if (q.rx_new && q.rx_word[anp_pkg::LCW_ACK]) begin
            next_q.ack_cnt = q.ack_cnt + 3'h1;
            if (q.ack_cnt + 3'h1 >= anp_pkg::ACK_NEED) begin
              next_q.st       = anp_pkg::st_ack_tail;
              next_q.sent_cnt = 4'h0;
            end
          end
        end else if (q.sent_cnt >= anp_pkg::ACK_TAIL) begin
          if ((q.adv & q.partner[8:5]) == 4'h0) begin
            renego = 1'b1; // no common ability
          end else begin
            next_q.st        = anp_pkg::st_linked;
            next_q.res_speed = res[1]; // RL7 RL23
            next_q.res_full  = res[0]; // RL7 RL23
            next_q.an_done   = 1'b1;
            next_q.link_up   = 1'b1;
          end
        end
      end
      anp_pkg::st_linked: begin
        ok = q.res_speed ? link_100_ok : link_10_ok;
        if (!ok) begin
          renego = 1'b1; // RL21
        end
      end
      default: begin
        next_q.st = anp_pkg::st_hold;
      end
    endcase

    // common entry to a fresh negotiation
    if (renego) begin
      next_q.st        = anp_pkg::st_detect; // RL1 RL21
      next_q.match_cnt = 3'h0;
      next_q.an_done   = 1'b0;
      next_q.link_up   = 1'b0;
    end
    if (start) begin
      next_q.match_cnt = 3'h0;
      next_q.an_done   = 1'b0;
      next_q.link_up   = 1'b0;
      next_q.timer     = 32'h0000_0000;
      if (next_q.pdown || !next_q.strap_done) begin
        next_q.st = anp_pkg::st_hold;
      end else if (!next_q.an_en) begin
        next_q.st = anp_pkg::st_forced; // RL14 RL24
      end else if (brk) begin
        next_q.st = anp_pkg::st_break; // RL22
      end else begin
        next_q.st = anp_pkg::st_detect; // RL1 RL2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_burst_length: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    q.tx_active |-> q.tx_pos <= anp_pkg::LAST_POS)
    else $error("burst runs past last pulse position");

  chk_clock_pulse: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    (sending && q.tx_active && q.ptimer == 32'h0000_0000 && !q.tx_pos[0]) |=> q.tx_pulse)
    else $error("clock pulse missing from burst");

  chk_data_pulse: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    (sending && q.tx_active && q.ptimer == 32'h0000_0000 && q.tx_pos[0])
      |=> q.tx_pulse == $past(data_bit))
    else $error("data pulse does not match code word");

  chk_word_fields: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    tx_word[4:0] == anp_pkg::SELECTOR && tx_word[8:5] == q.adv && !tx_word[15])
    else $error("code word selector or abilities wrong");

  chk_ack_sent: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    $rose(q.st == anp_pkg::st_ack_wait) |-> tx_word[anp_pkg::LCW_ACK])
    else $error("acknowledge bit not set after match");

  chk_resolve_best: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    ($rose(q.link_up) && q.lp_an_able && q.an_en) |-> {q.res_speed, q.res_full} == res)
    else $error("resolved mode is not the best common one");

  chk_pd_half: assert property (@(posedge clk) disable iff (!rst_b) // RL17
    ($rose(q.link_up) && !q.lp_an_able && q.an_en) |-> !q.res_full && q.an_done)
    else $error("parallel detected link not half duplex");

  chk_link_loss: assert property (@(posedge clk) disable iff (!rst_b) // RL21
    (q.st == anp_pkg::st_linked && !(q.res_speed ? link_100_ok : link_10_ok)
      && !((read || write) && !q.bus_ack)) |=> q.st == anp_pkg::st_detect && !q.link_up)
    else $error("link loss did not restart negotiation");

  chk_break_hold: assert property (@(posedge clk) disable iff (!rst_b) // RL22
    ($rose(link_hold) && !write) |-> link_hold[*2] ##1 (link_hold || !write))
    else $error("link drop ended early");

  chk_forced_mode: assert property (@(posedge clk) disable iff (!rst_b) // RL24
    (q.st == anp_pkg::st_forced) |=> (q.st != anp_pkg::st_forced) ||
      (q.res_speed == $past(q.speed_sel) && q.res_full == $past(q.duplex_sel)))
    else $error("forced speed or duplex not applied");
endmodule
`default_nettype wire

/* tb/link_partner_model.sv */
// far-side link partner: sends fast link pulse bursts carrying its code word
`timescale 1ns/1ps
`default_nettype none
module link_partner_model #(
  parameter int PG = 8,
  parameter int BG = 600
) (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] word,
  output logic             rx_pulse
);
  int          nb;
  logic [15:0] w;
  ////////////////////////////////////////////////////////////////////////////////
  // one burst per interval; acknowledge bit set from the fourth burst on,
  // as a partner that has seen our word three times would do
  initial begin
    rx_pulse = 1'b0;
    nb = 0;
    forever begin
      @(posedge clk);
      if (!en) begin
        nb = 0;
      end else begin
        w = (nb >= 3) ? (word | 16'h4000) : word;
        nb++;
        for (int k = 0; k < 33; k++) begin
          rx_pulse <= (k % 2 == 0) ? 1'b1 : w[k / 2];
          @(posedge clk);
          rx_pulse <= 1'b0;
          repeat (PG - 1) @(posedge clk);
        end
        repeat (BG - 33 * PG) @(posedge clk);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_link_autonegotiation.sv */
// self-checking bench for the auto-negotiation block
`timescale 1ns/1ps
`default_nettype none
module test_link_autonegotiation;
  localparam int PG = 8;
  localparam int BG = 600;
  localparam int BL = 50;
  logic        clk, rst_b, read, write, rx_pulse, link_100_ok, link_10_ok, pen;
  logic        waitrequest, tx_pulse, link_hold, link_up, speed_100, full_duplex;
  logic [7:0]  address;
  logic [2:0]  mode_strap;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] w, pword;
  int          error_cnt, cmp_count, n, cnt;
  link_autonegotiation #(.PULSE_GAP_CYC(PG), .BURST_GAP_CYC(BG), .NO_BURST_CYC(2000),
    .BREAK_LINK_CYC(BL)) i_dut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .mode_strap(mode_strap), .rx_pulse(rx_pulse), .link_100_ok(link_100_ok),
    .link_10_ok(link_10_ok), .tx_pulse(tx_pulse), .link_hold(link_hold), .link_up(link_up),
    .speed_100(speed_100), .full_duplex(full_duplex));
  link_partner_model #(.PG(PG), .BG(BG)) i_partner (.clk(clk), .en(pen), .word(pword),
    .rx_pulse(rx_pulse));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic fail_to(input string what);
    error_cnt++;
    $display("ERROR %0t timeout %s", $time, what);
    tally_and_finish();
  endtask
  // request held until the edge where waitrequest is seen low, data taken there
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d);
    int k;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    read <= !wr;
    write <= wr;
    k = 0;
    do begin @(posedge clk); k++; end while (waitrequest !== 1'b0 && k < 20);
    if (waitrequest !== 1'b0) fail_to("bus");
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wait_link(input logic lvl, input int lim);
    int k;
    k = 0;
    do begin @(negedge clk); k++; end while (link_up !== lvl && k < lim);
    if (link_up !== lvl) fail_to("link");
  endtask
  // a burst starts with a pulse after a quiet gap; later positions are PG apart
  task automatic cap_burst(output logic [15:0] word);
    int k, q, clocks;
    k = 0;
    q = 0;
    clocks = 1;
    word = 16'h0000;
    while (!(tx_pulse === 1'b1 && q >= 4 * PG) && k < 3000) begin
      q = (tx_pulse === 1'b1) ? 0 : q + 1;
      @(negedge clk);
      k++;
    end
    if (k >= 3000) fail_to("burst");
    for (int p = 1; p < 33; p++) begin
      repeat (PG) @(negedge clk);
      if (p % 2 == 0) clocks += (tx_pulse === 1'b1);
      else word[p / 2] = tx_pulse;
    end
    chk(clocks, 17, "clock pulses");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(0, anp_pkg::REG_ADV, 16'h0000);
    chk(rd, 32'h000001E1, "adv");
    bus(0, anp_pkg::REG_STATUS, 16'h0000);
    chk(rd[3], 1'b1, "able");
    bus(0, 6'h02, 16'h0000);
    chk(rd, 32'h00000000, "unmapped");
  endtask
  task automatic t_burst;
    cap_burst(w);
    chk(w[4:0], anp_pkg::SELECTOR, "selector");
    chk(w[8:5], 4'hF, "abilities");
    chk(w[15], 1'b0, "next page");
  endtask
  // partner lacks 100 full duplex, so 100 half must win
  // the line only reports lock once we are in the acknowledge phase, so
  // parallel detection cannot steal the link during the exchange
  task automatic t_negotiate;
    @(posedge clk);
    pword <= 16'h00E1;
    pen <= 1'b1;
    n = 0;
    do begin cap_burst(w); n++; end while (w[anp_pkg::LCW_ACK] !== 1'b1 && n < 12);
    chk(w[anp_pkg::LCW_ACK], 1'b1, "ack sent");
    @(posedge clk);
    link_100_ok <= 1'b1;
    wait_link(1'b1, 30000);
    chk({speed_100, full_duplex}, 2'b10, "resolved");
    bus(0, anp_pkg::REG_VENDOR, 16'h0000);
    chk({rd[12], rd[4:2]}, 4'hA, "vendor");
    bus(0, anp_pkg::REG_PARTNER, 16'h0000);
    chk(rd[15:0] & anp_pkg::LCW_MASK, 16'h00E1, "partner");
    bus(0, anp_pkg::REG_EXPAND, 16'h0000);
    chk(rd[0], 1'b1, "lp able");
    pen <= 1'b0;
    link_100_ok <= 1'b0;
    wait_link(1'b0, 10);
  endtask
  task automatic t_parallel;
    @(posedge clk);
    link_10_ok <= 1'b1;
    wait_link(1'b1, 5000);
    chk({speed_100, full_duplex}, 2'b00, "pd mode");
    bus(0, anp_pkg::REG_EXPAND, 16'h0000);
    chk(rd[0], 1'b0, "lp able");
    bus(0, anp_pkg::REG_PARTNER, 16'h0000);
    chk({rd[7], rd[5]}, 2'b01, "pd speed");
    link_10_ok <= 1'b0;
    wait_link(1'b0, 10);
    @(posedge clk);
    link_100_ok <= 1'b1;
    link_10_ok <= 1'b1;
    n = 0;
    do begin bus(0, anp_pkg::REG_EXPAND, 16'h0000); n++; end while (rd[4] !== 1'b1 && n < 50);
    chk(rd[4], 1'b1, "pd fault");
    link_100_ok <= 1'b0;
    link_10_ok <= 1'b0;
  endtask
  // the break wait is timed from after the write completes, so allow slack
  task automatic t_restart;
    bus(1, anp_pkg::REG_ADV, 16'h0040);
    @(negedge clk);
    chk(link_hold, 1'b0, "no restart");
    bus(0, anp_pkg::REG_ADV, 16'h0000);
    chk(rd[15:0], 16'h0041, "adv wr");
    bus(1, anp_pkg::REG_CTRL, 16'h1200);
    @(negedge clk);
    cnt = 0;
    n = 0;
    while (link_hold === 1'b1 && cnt < BL + 20) begin
      n += (tx_pulse === 1'b1);
      @(negedge clk);
      cnt++;
    end
    chk(cnt >= BL - 4 && cnt <= BL, 1'b1, "break time");
    chk(n, 0, "quiet in break");
    bus(0, anp_pkg::REG_CTRL, 16'h0000);
    chk(rd[12:9], 4'h8, "ctrl");
    cap_burst(w);
    chk(w[8:5], 4'h2, "new adv");
  endtask
  task automatic t_forced;
    bus(1, anp_pkg::REG_CTRL, 16'h2100);
    link_100_ok <= 1'b1;
    wait_link(1'b1, 20);
    chk({speed_100, full_duplex}, 2'b11, "forced");
    repeat (PG * 34) @(negedge clk);
    n = 0;
    repeat (2 * BG) begin @(negedge clk); n += (tx_pulse === 1'b1); end
    chk(n, 0, "no bursts");
    @(posedge clk);
    link_100_ok <= 1'b0;
    wait_link(1'b0, 20);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, overall watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_to("run");
  end
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    mode_strap = 3'h7;
    link_100_ok = 1'b0;
    link_10_ok = 1'b0;
    pen = 1'b0;
    pword = 16'h0000;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_burst();
    t_negotiate();
    t_parallel();
    t_restart();
    t_forced();
    tally_and_finish();
  end
endmodule
`default_nettype wire
